// ---- logic/ecs_ext_control.sv ----
// Functional notes
// [R1] Tare contact closing zeroes the reading once.
// [R2] Peak contact held shows stored peak, flashing.
// [R3] Valley contact held shows stored valley, flashing.
// [R4] Reset contact: scope 0 hard reset, scope 1 clears peak/valley only.
// [R5] Hold contact grounded freezes the displayed value.
// [R6] During hold, sampling, outputs, alarms and peak/valley keep updating.
// [R7] Lockout grounded rejects configuration changes and nonvolatile writes.
// [R8] Lockout grounded in run mode ignores menu presses, no setup entry.
// [R9] Print enabled: print contact starts a serial printout.
// [R10] Alarm reset enabled: print contact clears latched alarms.
// [R11] Comm settings change only when all five lock bits are zero.
// [R12] Parity: 0 none, 1 odd, 2 even.
// [R13] Stop bits: 0 gives one, 1 gives two.
// [R14] Host gives each bus meter a distinct address, 001 alone.
// [R15] Host steps baud, parity, stop bits to find settings.
// [R16] Baud selectable 300 to 19200, default 9600.
// [R17] Contacts are synchronised, debounced, active low, momentary acts once.
//
// Purpose: External contact control and serial setup registers
// Assumes: Contacts are active low; the measurement core is outside
// Notes: Readings are signed 24-bit counts
//
// Our own choices: the address map and register access over Avalon-MM.
module ecs_ext_control #(
	parameter int DEBOUNCE = ecs_pkg::DEBOUNCE_CYCLES,
	parameter int FLASH = ecs_pkg::FLASH_CYCLES
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// Contact pins, low when grounded
	input wire logic i_tare_n,
	input wire logic i_peak_sel_n,
	input wire logic i_valley_sel_n,
	input wire logic i_ext_reset_n,
	input wire logic i_hold_n,
	input wire logic i_lockout_n,
	input wire logic i_print_n,
	// Measurement and front panel
	input wire logic i_sample_valid,
	input wire logic [23:0] i_sample,
	input wire logic i_menu_press,
	input wire logic i_setup_exit,
	input wire logic i_nv_write_req,
	// Display and actions
	output logic [23:0] o_display_value,
	output logic o_display_blank,
	output logic [23:0] o_live_reading,
	output logic [23:0] o_peak_reading,
	output logic [23:0] o_valley_reading,
	output logic o_hard_reset_indication,
	output logic o_print_start,
	output logic o_alarm_latch_clear,
	output logic o_setup_mode,
	output logic o_nv_write_grant,
	// Serial setup
	output logic [1:0] o_parity_select,
	output logic o_stop_bits_select,
	output logic [2:0] o_baud_select,
	output logic [7:0] o_device_bus_address
);
	////////////////////////////////////////////////////////////////////////////
	// Contact conditioning
	logic [6:0] pin_n;
	logic [6:0] lvl;
	logic [6:0] pls;
	assign pin_n = {i_print_n, i_lockout_n, i_hold_n, i_ext_reset_n,
		i_valley_sel_n, i_peak_sel_n, i_tare_n};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_db
			ecs_debounce #(.CYCLES(DEBOUNCE)) u_db (
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_pin_n(pin_n[gi]),
				.o_level(lvl[gi]),
				.o_pulse(pls[gi])
			); // R17
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Register bus
	logic wr_stb;
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] ctrl_rd;
	logic [31:0] ser_rd;
	logic [31:0] stat_rd;
	logic [31:0] live_rd;

	ecs_avalon_regs u_regs (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_address(i_address),
		.i_read(i_read),
		.i_write(i_write),
		.i_writedata(i_writedata),
		.o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest),
		.o_wr_stb(wr_stb),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.i_ctrl(ctrl_rd),
		.i_serial(ser_rd),
		.i_status(stat_rd),
		.i_live(live_rd)
	);

	////////////////////////////////////////////////////////////////////////////
	// Core state
	typedef struct packed {
		logic reset_scope_select;
		logic print_enable;
		logic alarm_latch_reset_enable;
		logic [4:0] comm_lock_bits;
		logic [1:0] parity_select;
		logic stop_bits_select;
		logic [2:0] baud_select;
		logic [7:0] device_bus_address;
		logic [23:0] tare_offset;
		logic [23:0] live;
		logic [23:0] peak;
		logic [23:0] valley;
		logic pv_valid;
		logic [23:0] disp;
		logic blank;
		logic [31:0] flash_cnt;
		logic hard_rst;
		logic print_start;
		logic alarm_clear;
		logic setup_mode;
		logic nv_grant;
		logic cfg_reject;
	} ecs_core_t;
	ecs_core_t st_reg;
	ecs_core_t st_next;

	logic [23:0] net;
	logic locked;
	logic cfg_wr;
	logic peak_on;
	logic valley_on;
	assign net = i_sample - st_reg.tare_offset;
	assign locked = lvl[5];
	assign cfg_wr = wr_stb && wr_data[ecs_pkg::CTRL_CFG_WRITE];
	assign peak_on = lvl[1];
	assign valley_on = lvl[2] && !lvl[1];

	// Next state for configuration, records, display and actions
	always_comb
	begin
		st_next = st_reg;
		st_next.print_start = 1'b0;
		st_next.alarm_clear = 1'b0;
		st_next.hard_rst = 1'b0;
		st_next.cfg_reject = 1'b0;
		// Control register writes need the commit bit so plain writes stay harmless; serial writes apply without it
		if (wr_stb && wr_addr == ecs_pkg::OFS_CTRL)
		begin
			if (locked)
				st_next.cfg_reject = 1'b1; // R7
			else if (cfg_wr)
			begin
				st_next.reset_scope_select = wr_data[ecs_pkg::CTRL_RESET_SCOPE];
				st_next.print_enable = wr_data[ecs_pkg::CTRL_PRINT_EN];
				st_next.alarm_latch_reset_enable = wr_data[ecs_pkg::CTRL_ALARM_RST_EN];
				st_next.comm_lock_bits = wr_data[ecs_pkg::CTRL_LOCK_LO +: ecs_pkg::CTRL_LOCK_W];
			end
		end
		if (wr_stb && wr_addr == ecs_pkg::OFS_SERIAL)
		begin
			// All five lock bits must be clear before comm settings move
			if (locked || st_reg.comm_lock_bits != 5'h00)
				st_next.cfg_reject = 1'b1; // R11
			else
			begin
				if (wr_data[ecs_pkg::SER_PARITY_LO +: 2] <= ecs_pkg::PARITY_EVEN)
					st_next.parity_select = wr_data[ecs_pkg::SER_PARITY_LO +: 2]; // R12
				st_next.stop_bits_select = wr_data[ecs_pkg::SER_STOP]; // R13
				if (wr_data[ecs_pkg::SER_BAUD_LO +: 3] <= ecs_pkg::BAUD_MAX)
					st_next.baud_select = wr_data[ecs_pkg::SER_BAUD_LO +: 3]; // R16
				st_next.device_bus_address = wr_data[ecs_pkg::SER_ADDR_LO +: 8];
			end
		end
		// Tare captures the raw sample as the new zero
		if (pls[0])
			st_next.tare_offset = i_sample; // R1
		// Sampling and records run regardless of hold
		if (i_sample_valid)
		begin
			st_next.live = net; // R6
			if (!st_reg.pv_valid || $signed(net) > $signed(st_reg.peak))
				st_next.peak = net;
			if (!st_reg.pv_valid || $signed(net) < $signed(st_reg.valley))
				st_next.valley = net;
			st_next.pv_valid = 1'b1;
		end
		// External reset, scope chosen by setting
		if (pls[3])
		begin
			// A sample in the same cycle wins and opens the new records
			st_next.pv_valid = i_sample_valid; // R4
			if (i_sample_valid)
			begin
				st_next.peak = net;
				st_next.valley = net;
			end
			if (!st_reg.reset_scope_select)
			begin
				st_next.hard_rst = 1'b1; // R4
				st_next.tare_offset = 24'h0;
				st_next.setup_mode = 1'b0;
			end
		end
		// Print and alarm reset share one contact
		if (pls[6])
		begin
			st_next.print_start = st_reg.print_enable; // R9
			st_next.alarm_clear = st_reg.alarm_latch_reset_enable; // R10
		end
		// Menu entry blocked by lockout while running
		if (i_menu_press && !st_reg.setup_mode && !locked)
			st_next.setup_mode = 1'b1; // R8
		else if (i_setup_exit)
			st_next.setup_mode = 1'b0;
		st_next.nv_grant = i_nv_write_req && !locked; // R7
		// Flash timer toggles blanking while a record is shown
		if (peak_on || valley_on)
		begin
			if (st_reg.flash_cnt >= 32'(FLASH - 1))
			begin
				st_next.flash_cnt = 32'h0;
				st_next.blank = !st_reg.blank;
			end
			else
				st_next.flash_cnt = st_reg.flash_cnt + 32'h1;
		end
		else
		begin
			st_next.flash_cnt = 32'h0;
			st_next.blank = 1'b0;
		end
		// Display source; hold freezes it
		if (!lvl[4])
		begin
			if (peak_on)
				st_next.disp = st_reg.peak; // R2
			else if (valley_on)
				st_next.disp = st_reg.valley; // R3
			else
				st_next.disp = st_reg.live;
		end // R5
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			st_reg <= '0;
			st_reg.comm_lock_bits <= ecs_pkg::LOCK_RESET;
			st_reg.parity_select <= ecs_pkg::PARITY_RESET;
			st_reg.baud_select <= ecs_pkg::BAUD_RESET;
			st_reg.device_bus_address <= ecs_pkg::ADDR_RESET;
		end
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register readback and outputs
	assign ctrl_rd = {24'h0, st_reg.comm_lock_bits, st_reg.alarm_latch_reset_enable,
		st_reg.print_enable, st_reg.reset_scope_select};
	assign ser_rd = {16'h0, st_reg.device_bus_address, 1'b0, st_reg.baud_select,
		1'b0, st_reg.stop_bits_select, st_reg.parity_select};
	assign stat_rd = {22'h0, st_reg.cfg_reject, st_reg.setup_mode, st_reg.pv_valid,
		lvl};
	assign live_rd = {8'h0, st_reg.live};

	assign o_display_value = st_reg.disp;
	assign o_display_blank = st_reg.blank;
	assign o_live_reading = st_reg.live;
	assign o_peak_reading = st_reg.peak;
	assign o_valley_reading = st_reg.valley;
	assign o_hard_reset_indication = st_reg.hard_rst;
	assign o_print_start = st_reg.print_start;
	assign o_alarm_latch_clear = st_reg.alarm_clear;
	assign o_setup_mode = st_reg.setup_mode;
	assign o_nv_write_grant = st_reg.nv_grant;
	assign o_parity_select = st_reg.parity_select;
	assign o_stop_bits_select = st_reg.stop_bits_select;
	assign o_baud_select = st_reg.baud_select;
	assign o_device_bus_address = st_reg.device_bus_address;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_tare_capture: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
		pls[0] |=> st_reg.tare_offset == $past(i_sample)) else $error("tare not taken");
	chk_peak_display: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
		peak_on && !lvl[4] |=> o_display_value == $past(st_reg.peak))
		else $error("peak not shown");
	chk_valley_display: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
		valley_on && !lvl[4] |=> o_display_value == $past(st_reg.valley))
		else $error("valley not shown");
	chk_reset_scope: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
		pls[3] |=> o_hard_reset_indication == !$past(st_reg.reset_scope_select)
		&& st_reg.pv_valid == $past(i_sample_valid)) else $error("reset scope wrong");
	chk_hold_freeze: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
		lvl[4] && $past(lvl[4]) |-> $stable(o_display_value))
		else $error("display moved in hold");
	chk_sample_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
		i_sample_valid && lvl[4] |=> o_live_reading == $past(net))
		else $error("sampling stopped");
	chk_nv_lockout: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
		locked && $past(locked) |-> !o_nv_write_grant) else $error("nv write in lockout");
	chk_menu_lockout: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
		locked && !o_setup_mode |=> !o_setup_mode) else $error("setup entered in lockout");
	chk_print_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
		pls[6] |=> o_print_start == $past(st_reg.print_enable)) else $error("print wrong");
	chk_alarm_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R10
		pls[6] |=> o_alarm_latch_clear == $past(st_reg.alarm_latch_reset_enable))
		else $error("alarm clear wrong");
	chk_comm_lock: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
		st_reg.comm_lock_bits != 5'h00 && !(wr_stb && wr_addr == ecs_pkg::OFS_CTRL)
		|=> $stable(o_device_bus_address) && $stable(o_parity_select)) else $error("comm moved");
	chk_parity_range: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
		o_parity_select <= ecs_pkg::PARITY_EVEN && o_baud_select <= ecs_pkg::BAUD_MAX)
		else $error("bad encoding");
endmodule

// ---- logic/ecs_pkg.sv ----
// Purpose: Shared constants for the external control and serial setup block
// Assumes: 100 MHz clock, Avalon-MM register access with waitrequest
// Notes: Register offsets are byte addresses of aligned 32-bit words
package ecs_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 100;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;
	localparam int FLASH_MS = 250;
	localparam int FLASH_CYCLES = FLASH_MS * 1000 * CLK_MHZ;
	// Register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_SERIAL = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_LIVE = 4'hC;
	// Control field positions
	localparam int CTRL_RESET_SCOPE = 0;
	localparam int CTRL_PRINT_EN = 1;
	localparam int CTRL_ALARM_RST_EN = 2;
	localparam int CTRL_LOCK_LO = 3;
	localparam int CTRL_LOCK_W = 5;
	localparam int CTRL_CFG_WRITE = 8;
	// Serial field positions
	localparam int SER_PARITY_LO = 0;
	localparam int SER_STOP = 2;
	localparam int SER_BAUD_LO = 4;
	localparam int SER_ADDR_LO = 8;
	// Reset values
	localparam logic [4:0] LOCK_RESET = 5'h1F;
	localparam logic [1:0] PARITY_RESET = 2'h0;
	localparam logic [2:0] BAUD_RESET = 3'h5;
	localparam logic [7:0] ADDR_RESET = 8'h01;
	// Encodings
	localparam logic [1:0] PARITY_NONE = 2'h0;
	localparam logic [1:0] PARITY_ODD = 2'h1;
	localparam logic [1:0] PARITY_EVEN = 2'h2;
	localparam logic [2:0] BAUD_MAX = 3'h6;
	// Baud codes 0..6 = 300,600,1200,2400,4800,9600,19200
endpackage

// ---- logic/ecs_debounce.sv ----
// Purpose: Synchronise and debounce one active-low contact input
// Assumes: Pin is asynchronous to i_ref_clk
// Notes: Emits a one-cycle pulse on each new assertion
module ecs_debounce #(
	parameter int CYCLES = ecs_pkg::DEBOUNCE_CYCLES
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Contact pin, low when grounded
	input wire logic i_pin_n,
	// Debounced level and assertion pulse
	output logic o_level,
	output logic o_pulse
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic level;
		logic pulse;
		logic [31:0] cnt;
	} ecs_db_t;
	ecs_db_t st_reg;
	ecs_db_t st_next;

	// Count stable cycles; a bouncing contact restarts the count
	always_comb
	begin
		st_next = st_reg;
		st_next.sync1 = ~i_pin_n;
		st_next.sync2 = st_reg.sync1;
		st_next.pulse = 1'b0;
		if (st_reg.sync2 == st_reg.level)
			st_next.cnt = 32'h0;
		else if (st_reg.cnt >= 32'(CYCLES - 1))
		begin
			st_next.cnt = 32'h0;
			st_next.level = st_reg.sync2;
			st_next.pulse = st_reg.sync2;
		end
		else
			st_next.cnt = st_reg.cnt + 32'h1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_level = st_reg.level;
	assign o_pulse = st_reg.pulse;

	chk_pulse_on_rise: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R17
		o_pulse |-> o_level && !$past(o_level)) else $error("pulse without rise");
endmodule

// ---- logic/ecs_avalon_regs.sv ----
// Purpose: Avalon-MM slave for the block's registers
// Assumes: One-cycle waitrequest answer on every access
// Notes: Unmapped reads return zero, unmapped writes are dropped
module ecs_avalon_regs
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// Decoded access towards the core
	output logic o_wr_stb,
	output logic [3:0] o_wr_addr,
	output logic [31:0] o_wr_data,
	input wire logic [31:0] i_ctrl,
	input wire logic [31:0] i_serial,
	input wire logic [31:0] i_status,
	input wire logic [31:0] i_live
);
	typedef struct packed {
		logic ack;
		logic wait_req;
		logic [31:0] rdata;
	} ecs_bus_t;
	ecs_bus_t st_reg;
	ecs_bus_t st_next;

	function automatic logic [31:0] read_mux(input logic [3:0] a, input logic [31:0] c,
		input logic [31:0] s, input logic [31:0] t, input logic [31:0] l);
		case (a)
			ecs_pkg::OFS_CTRL: read_mux = c;
			ecs_pkg::OFS_SERIAL: read_mux = s;
			ecs_pkg::OFS_STATUS: read_mux = t;
			ecs_pkg::OFS_LIVE: read_mux = l;
			default: read_mux = 32'h0;
		endcase
	endfunction

	// Waitrequest drops one cycle after the request is seen
	always_comb
	begin
		st_next = st_reg;
		st_next.ack = (i_read || i_write) && !st_reg.ack;
		// Kept as its own flop so the pin needs no inverter after the register
		st_next.wait_req = !st_next.ack;
		st_next.rdata = read_mux(i_address, i_ctrl, i_serial, i_status, i_live);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			st_reg <= '0;
			st_reg.wait_req <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign o_waitrequest = st_reg.wait_req;
	assign o_readdata = st_reg.rdata;
	assign o_wr_stb = i_write && st_reg.ack;
	assign o_wr_addr = i_address;
	assign o_wr_data = i_writedata;
endmodule

// ---- dv/ecs_contact_model.sv ----
// Purpose: Bank of external contacts wired to the block's pins
// Assumes: Pins have pull-ups, so an open contact reads high
// Notes: Chatter gives one-cycle bounces, shorter than the debounce time
module ecs_contact_model #(
	parameter int CHATTER = 3
)
(
	// Clock
	input wire logic i_ref_clk,
	// Commands from the bench
	input wire logic [6:0] i_close,
	input wire logic i_chatter,
	// Pins towards the block
	output logic [6:0] o_pin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] prev_reg = 7'h00;
	logic [3:0] cnt_reg [7];
	initial o_pin_n = 7'h7F;
	initial foreach (cnt_reg[b]) cnt_reg[b] = 4'h0;
	//////////////////////////////////////////////////////////////////
	// A closing contact may chatter before it settles low
	always @(posedge i_ref_clk)
	begin
		prev_reg <= i_close;
		for (int b = 0; b < 7; b++)
		begin
			if (i_close[b] && !prev_reg[b])
				cnt_reg[b] <= i_chatter ? 4'(CHATTER * 2) : 4'h0;
			else if (cnt_reg[b] != 4'h0)
				cnt_reg[b] <= cnt_reg[b] - 4'h1;
			o_pin_n[b] <= !i_close[b] ? 1'b1 : (cnt_reg[b] != 4'h0 ? cnt_reg[b][0] : 1'b0);
		end
	end
endmodule

// ---- dv/external_control_and_serial_setup_tb_top.sv ----
// Purpose: Self-checking bench for the external control block
// Assumes: Short debounce and flash counts of 4 cycles
// Notes: Contact levels are polled through the status register
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module external_control_and_serial_setup_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_address = 4'h0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [6:0] close = 7'h00;
	logic chatter = 1'b0;
	logic [6:0] pin_n;
	logic i_sample_valid = 1'b0;
	logic [23:0] i_sample = 24'h0;
	logic i_menu_press = 1'b0;
	logic i_setup_exit = 1'b0;
	logic i_nv_write_req = 1'b0;
	logic [31:0] o_readdata;
	logic o_waitrequest;
	logic [23:0] o_display_value, o_live_reading, o_peak_reading, o_valley_reading;
	logic o_display_blank, o_hard_reset_indication, o_print_start, o_alarm_latch_clear;
	logic o_setup_mode, o_nv_write_grant, o_stop_bits_select;
	logic [1:0] o_parity_select;
	logic [2:0] o_baud_select;
	logic [7:0] o_device_bus_address;
	int fails = 0;
	int checks = 0;
	int n_hard = 0;
	int n_print = 0;
	int n_alarm = 0;
	logic [31:0] rd;
	//////////////////////////////////////////////////////////////////
	// Clock, contacts and the block
	always #5 i_ref_clk = ~i_ref_clk;
	ecs_contact_model u_contacts (.i_ref_clk(i_ref_clk), .i_close(close), .i_chatter(chatter),
		.o_pin_n(pin_n));
	ecs_ext_control #(.DEBOUNCE(4), .FLASH(4)) u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_tare_n(pin_n[0]),
		.i_peak_sel_n(pin_n[1]), .i_valley_sel_n(pin_n[2]), .i_ext_reset_n(pin_n[3]),
		.i_hold_n(pin_n[4]), .i_lockout_n(pin_n[5]), .i_print_n(pin_n[6]),
		.i_sample_valid(i_sample_valid), .i_sample(i_sample), .i_menu_press(i_menu_press),
		.i_setup_exit(i_setup_exit), .i_nv_write_req(i_nv_write_req),
		.o_display_value(o_display_value), .o_display_blank(o_display_blank),
		.o_live_reading(o_live_reading), .o_peak_reading(o_peak_reading),
		.o_valley_reading(o_valley_reading), .o_hard_reset_indication(o_hard_reset_indication),
		.o_print_start(o_print_start), .o_alarm_latch_clear(o_alarm_latch_clear),
		.o_setup_mode(o_setup_mode), .o_nv_write_grant(o_nv_write_grant),
		.o_parity_select(o_parity_select), .o_stop_bits_select(o_stop_bits_select),
		.o_baud_select(o_baud_select), .o_device_bus_address(o_device_bus_address));
	// Pulse tallies, so a one-cycle action is never missed by polling
	always @(posedge i_ref_clk)
	begin
		if (o_hard_reset_indication === 1'b1) n_hard++;
		if (o_print_start === 1'b1) n_print++;
		if (o_alarm_latch_clear === 1'b1) n_alarm++;
	end
	//////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One Avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		@(posedge i_ref_clk);
		i_address <= a;
		i_writedata <= wd;
		i_write <= wr;
		i_read <= !wr;
		for (n = 0; n < 20; n++)
		begin
			@(posedge i_ref_clk);
			if (o_waitrequest === 1'b0)
				break;
		end
		rd = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
		// Let the edge that launches the write pass, so checks see settled outputs
		@(posedge i_ref_clk);
		if (n == 20)
		begin
			fails++;
			wrap_up();
		end
	endtask
	// Poll the debounced level of one contact, bounded
	task automatic wait_level(input int idx, input logic v);
		int n;
		for (n = 0; n < 60; n++)
		begin
			bus(1'b0, ecs_pkg::OFS_STATUS, 32'h0);
			if (rd[idx] === v)
				break;
		end
		repeat (3) @(posedge i_ref_clk);
		if (n == 60)
		begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic contact(input int idx, input logic v);
		@(posedge i_ref_clk);
		close[idx] <= v;
		wait_level(idx, v);
	endtask
	task automatic sample(input logic [23:0] v);
		@(posedge i_ref_clk);
		i_sample <= v;
		i_sample_valid <= 1'b1;
		@(posedge i_ref_clk);
		i_sample_valid <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask
	// Committed control write: commit bit plus fields
	task automatic ctrl(input logic [7:0] f);
		bus(1'b1, ecs_pkg::OFS_CTRL, {23'h0, 1'b1, f});
	endtask
	//////////////////////////////////////////////////////////////////
	task automatic t_reset();
		`CHK("parity", 2'h0, o_parity_select)
		`CHK("baud", 3'h5, o_baud_select)
		`CHK("address", 8'h01, o_device_bus_address)
		bus(1'b0, ecs_pkg::OFS_CTRL, 32'h0);
		`CHK("ctrl", 32'h000000F8, rd)
		bus(1'b0, 4'h2, 32'h0);
		`CHK("unmapped", 32'h00000000, rd)
		bus(1'b1, ecs_pkg::OFS_SERIAL, 32'h00002261);
		`CHK("locked parity", 2'h0, o_parity_select)
		$display("test reset done");
	endtask
	task automatic t_serial();
		ctrl(8'h80);
		bus(1'b1, ecs_pkg::OFS_SERIAL, 32'h00002261);
		`CHK("one lock bit", 3'h5, o_baud_select)
		ctrl(8'h00);
		for (int p = 0; p < 3; p++)
		begin
			bus(1'b1, ecs_pkg::OFS_SERIAL, {16'h0, 8'(8'h10 + p), 1'b0, 3'(p + 4), 1'b0,
				1'(p), 2'(p)});
			`CHK("parity", 2'(p), o_parity_select)
			`CHK("stop", 1'(p), o_stop_bits_select)
			`CHK("baud", 3'(p + 4), o_baud_select)
			`CHK("address", 8'(8'h10 + p), o_device_bus_address)
		end
		// Parity code 3 and baud code 7 are not legal and must leave parity and baud alone
		bus(1'b1, ecs_pkg::OFS_SERIAL, 32'h00000073);
		`CHK("parity 3 ignored", 2'h2, o_parity_select)
		`CHK("baud 7 ignored", 3'h6, o_baud_select)
		$display("test serial done");
	endtask
	task automatic t_lockout();
		contact(5, 1'b1);
		ctrl(8'h02);
		bus(1'b0, ecs_pkg::OFS_CTRL, 32'h0);
		`CHK("locked ctrl", 32'h00000000, rd)
		i_nv_write_req <= 1'b1;
		i_menu_press <= 1'b1;
		@(posedge i_ref_clk);
		i_menu_press <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		`CHK("nv grant", 1'b0, o_nv_write_grant)
		`CHK("setup", 1'b0, o_setup_mode)
		contact(5, 1'b0);
		`CHK("nv grant", 1'b1, o_nv_write_grant)
		i_nv_write_req <= 1'b0;
		i_menu_press <= 1'b1;
		@(posedge i_ref_clk);
		i_menu_press <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		`CHK("setup", 1'b1, o_setup_mode)
		i_setup_exit <= 1'b1;
		@(posedge i_ref_clk);
		i_setup_exit <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		`CHK("setup", 1'b0, o_setup_mode)
		$display("test lockout done");
	endtask
	task automatic t_records();
		int hi;
		int lo;
		sample(24'h00000A);
		sample(24'h00001E);
		sample(24'hFFFFFB);
		contact(1, 1'b1);
		hi = 0;
		lo = 0;
		repeat (20)
		begin
			@(posedge i_ref_clk);
			if (o_display_blank === 1'b1) hi++;
			if (o_display_blank === 1'b0) lo++;
		end
		`CHK("peak shown", 24'h00001E, o_display_value)
		`CHK("flashing", 1'b1, hi > 0 && lo > 0)
		contact(2, 1'b1);
		`CHK("peak first", 24'h00001E, o_display_value)
		contact(1, 1'b0);
		`CHK("valley shown", 24'hFFFFFB, o_display_value)
		contact(2, 1'b0);
		`CHK("live shown", 24'hFFFFFB, o_display_value)
		contact(4, 1'b1);
		sample(24'h000032);
		`CHK("frozen", 24'hFFFFFB, o_display_value)
		`CHK("live", 24'h000032, o_live_reading)
		`CHK("peak", 24'h000032, o_peak_reading)
		contact(4, 1'b0);
		$display("test records done");
	endtask
	task automatic t_tare();
		sample(24'h000064);
		contact(0, 1'b1);
		sample(24'h000064);
		`CHK("tared", 24'h000000, o_live_reading)
		// Two samples with the contact still held: a level-driven tare would zero the second
		sample(24'h000096);
		sample(24'h000096);
		`CHK("tare once", 24'h000032, o_live_reading)
		contact(0, 1'b0);
		$display("test tare done");
	endtask
	task automatic t_ext_reset();
		int h;
		h = n_hard;
		contact(3, 1'b1);
		contact(3, 1'b0);
		`CHK("hard reset", h + 1, n_hard)
		sample(24'h000007);
		`CHK("tare gone", 24'h000007, o_live_reading)
		`CHK("valley", 24'h000007, o_valley_reading)
		ctrl(8'h01);
		sample(24'h000014);
		contact(3, 1'b1);
		contact(3, 1'b0);
		`CHK("no hard reset", h + 1, n_hard)
		sample(24'h000009);
		`CHK("peak cleared", 24'h000009, o_peak_reading)
		`CHK("valley cleared", 24'h000009, o_valley_reading)
		$display("test reset input done");
	endtask
	task automatic t_print();
		int p;
		int a;
		for (int m = 0; m < 4; m++)
		begin
			ctrl({5'h0, 1'(m >> 1), 1'(m), 1'b0});
			p = n_print;
			a = n_alarm;
			chatter <= 1'b1;
			contact(6, 1'b1);
			contact(6, 1'b0);
			`CHK("prints", p + (m & 1), n_print)
			`CHK("alarm clears", a + (m >> 1), n_alarm)
		end
		chatter <= 1'b0;
		$display("test print done");
	endtask
	//////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		t_reset();
		t_serial();
		t_lockout();
		t_records();
		t_tare();
		t_ext_reset();
		t_print();
		wrap_up();
	end
endmodule
